/* File: dac_ctrl_consts.svh */
// Numeric constants for the serial converter control block.
// Assumes inclusion by bare name from the package and the modules.
`ifndef DAC_CTRL_CONSTS_SVH
`define DAC_CTRL_CONSTS_SVH

// ============================================================
// Frame layout
`define FRAME_BITS 6'h20
`define CMD_BITS 6'h08
`define COUNT_MAX 6'h3f
`define CMD_MSB 31
`define CMD_LSB 28
`define DATA_MSB 23
`define CODE_LSB 6
`define SPAN_MSB 11
`define SPAN_LSB 8

// ============================================================
// Command codes
`define CMD_WR_SPAN 4'h2
`define CMD_WR_CODE 4'h3
`define CMD_UPDATE 4'h4
`define CMD_WR_SPAN_UPD 4'h6
`define CMD_WR_CODE_UPD 4'h7
`define CMD_RD_IN_SPAN 4'ha
`define CMD_RD_IN_CODE 4'hb
`define CMD_RD_DAC_SPAN 4'hc
`define CMD_RD_DAC_CODE 4'hd
`define CMD_NOP 4'hf

// ============================================================
// Reset values
`define RESET_CODE 18'h00000
`define RESET_SPAN 4'h0
// Idle levels of synchronised pins: strap bits 6..4, manual 3,
// load_n 2, clear_n 1, chip select 0
`define SYNC_IDLE 8'h07

`endif

/* File: dac_ctrl_pkg.sv */
// Types and shared decode for the serial converter control block.
// Assumes dac_ctrl_consts.svh is on the include path.
`include "dac_ctrl_consts.svh"

package dac_ctrl_pkg;

    // ============================================================
    // Readback pointer, one-hot
    typedef enum logic [3:0] {
        PTR_IN_SPAN = 4'h1,
        PTR_IN_CODE = 4'h2,
        PTR_DAC_SPAN = 4'h4,
        PTR_DAC_CODE = 4'h8
    } rb_ptr_t;

    // Code sits left-justified, low bits zero
    function automatic logic [23:0] code_word(input logic [17:0] c);
        code_word = {c, 6'h00};
    endfunction

    // Span sits in the low nibble of the second data byte
    function automatic logic [23:0] span_word(input logic [3:0] s);
        span_word = {12'h000, s, 8'h00};
    endfunction

    function automatic logic is_read_cmd(input logic [3:0] c);
        is_read_cmd = (c == `CMD_RD_IN_SPAN) || (c == `CMD_RD_IN_CODE) ||
            (c == `CMD_RD_DAC_SPAN) || (c == `CMD_RD_DAC_CODE);
    endfunction

endpackage

/* File: link_xfer_if.sv */
// Signals passing between the register side and the serial shifter.
// Except under clear or manual straps, words here are held stable by the frame protocol while read.
`timescale 1ns/1ps

interface link_xfer_if;
    logic [31:0] frame_word;
    logic [5:0] bit_count;
    logic frame_toggle;
    logic [23:0] rb_in_span;
    logic [23:0] rb_in_code;
    logic [23:0] rb_dac_span;
    logic [23:0] rb_dac_code;
    logic [23:0] rb_roll;

    modport link (
        output frame_word, bit_count, frame_toggle,
        input rb_in_span, rb_in_code, rb_dac_span, rb_dac_code, rb_roll
    );
    modport regs (
        input frame_word, bit_count, frame_toggle,
        output rb_in_span, rb_in_code, rb_dac_span, rb_dac_code, rb_roll
    );
endinterface

/* File: serial_frame_shifter.sv */
// Serial-clock side: shifts frames in and readback bits out.
// Assumes the serial clock only runs while chip select is low.
`timescale 1ns/1ps

module serial_frame_shifter
    import dac_ctrl_pkg::*;
(
    // Link pins
    input wire logic serial_clock,
    input wire logic chip_select_load,
    input wire logic serial_data_in,
    output logic serial_readback_out,
    // Reset and register side
    input wire logic sys_rst,
    link_xfer_if.link xfer
);

    logic fresh;
    logic [31:0] shift_in;
    logic [5:0] count;
    logic [5:0] next_count;
    logic toggle;
    logic [23:0] shift_out;
    logic [3:0] cmd;
    logic [23:0] pick;

    // ============================================================
    // Frame start marker, armed by chip select high or reset
    always_ff @(posedge serial_clock or posedge chip_select_load or
        posedge sys_rst) begin
        if (chip_select_load || sys_rst) begin
            fresh <= 1'b1;
        end else begin
            fresh <= 1'b0;
        end
    end

    // Count restarts on the first edge; saturates to flag long frames
    always_comb begin
        if (fresh) begin
            next_count = 6'h01;
        end else if (count == `COUNT_MAX) begin
            next_count = count;
        end else begin
            next_count = count + 6'h01;
        end
    end

    // Sample data on rising edges while selected
    always_ff @(posedge serial_clock or posedge sys_rst) begin
        if (sys_rst) begin
            shift_in <= 32'h00000000;
            count <= 6'h00;
            toggle <= 1'b0;
        end else if (!chip_select_load) begin
            shift_in <= {shift_in[30:0], serial_data_in};
            count <= next_count;
            if (next_count == `FRAME_BITS) begin
                toggle <= ~toggle; // Full frame event
            end
        end
    end

    // ============================================================
    // Readback source: read commands answer at once, others roll
    assign cmd = shift_in[7:4];
    always_comb begin
        pick = xfer.rb_roll;
        if (cmd == `CMD_RD_IN_SPAN) begin
            pick = xfer.rb_in_span;
        end else if (cmd == `CMD_RD_IN_CODE) begin
            pick = xfer.rb_in_code;
        end else if (cmd == `CMD_RD_DAC_SPAN) begin
            pick = xfer.rb_dac_span;
        end else if (cmd == `CMD_RD_DAC_CODE) begin
            pick = xfer.rb_dac_code;
        end
    end

    // Bits change on falling edges; low until the command byte is in
    always_ff @(negedge serial_clock or posedge chip_select_load or
        posedge sys_rst) begin
        if (chip_select_load || sys_rst) begin
            serial_readback_out <= 1'b0;
            shift_out <= 24'h000000;
        end else if (count == `CMD_BITS && !fresh) begin
            serial_readback_out <= pick[23];
            shift_out <= {pick[22:0], 1'b0};
        end else begin
            serial_readback_out <= shift_out[23];
            shift_out <= {shift_out[22:0], 1'b0};
        end
    end

    assign xfer.frame_word = shift_in;
    assign xfer.bit_count = count;
    assign xfer.frame_toggle = toggle;

endmodule // serial_frame_shifter

/* File: dac_serial_double_buffered_regs.sv */
// Top of the converter control block: register side on the system
// clock, serial shifter on the serial clock. Assumes pins are async.
`timescale 1ns/1ps

module dac_serial_double_buffered_regs
    import dac_ctrl_pkg::*;
(
    // System clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // Serial link
    input wire logic serial_clock,
    input wire logic chip_select_load,
    input wire logic serial_data_in,
    output logic serial_readback_out,
    output logic serial_readback_oe,
    // Asynchronous controls
    input wire logic async_clear_n,
    input wire logic async_load_n,
    // Range straps
    input wire logic manual_range_select,
    input wire logic range_strap_0,
    input wire logic range_strap_1,
    input wire logic range_strap_2,
    // Converter side
    output logic [17:0] dac_code,
    output logic [3:0] dac_range,
    output logic reset_flag_n
);

    // ============================================================
    // Declarations
    link_xfer_if xfer ();

    logic [6:0] pin_raw;
    logic [7:0] pin_meta;
    logic [7:0] pin_sync;
    logic cs_s;
    logic clear_n_s;
    logic load_n_s;
    logic manual_s;
    logic [2:0] strap_s;
    logic toggle_s;
    logic toggle_seen;
    logic cs_late;
    logic cs_late2;
    logic frame_go;
    logic [3:0] cmd;
    logic [23:0] data;
    logic wr_code_go;
    logic wr_span_go;
    logic upd_go;
    logic load_go;
    logic [17:0] in_code;
    logic [3:0] in_span;
    logic [3:0] dac_span;
    logic [17:0] next_in_code;
    logic [3:0] next_in_span;
    logic [3:0] live_span;
    rb_ptr_t rb_ptr;

    // ============================================================
    // Serial-clock side
    serial_frame_shifter u_shifter (
        .serial_clock(serial_clock),
        .chip_select_load(chip_select_load),
        .serial_data_in(serial_data_in),
        .serial_readback_out(serial_readback_out),
        .sys_rst(sys_rst),
        .xfer(xfer.link)
    );

    // ============================================================
    // Synchronisers for pins and the frame toggle
    assign pin_raw = {range_strap_2, range_strap_1, range_strap_0,
        manual_range_select, async_load_n, async_clear_n,
        chip_select_load};

    // Two flops per pin; the first feeds only the second
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_sync
            localparam logic [7:0] IDLE = `SYNC_IDLE;
            if (gi < 7) begin : g_pin
                always_ff @(posedge clock) begin
                    if (sys_rst) begin
                        pin_meta[gi] <= IDLE[gi];
                        pin_sync[gi] <= IDLE[gi];
                    end else begin
                        pin_meta[gi] <= pin_raw[gi];
                        pin_sync[gi] <= pin_meta[gi];
                    end
                end
            end else begin : g_tog
                always_ff @(posedge clock) begin
                    if (sys_rst) begin
                        pin_meta[gi] <= 1'b0;
                        pin_sync[gi] <= 1'b0;
                    end else begin
                        pin_meta[gi] <= xfer.frame_toggle;
                        pin_sync[gi] <= pin_meta[gi];
                    end
                end
            end
        end
    endgenerate

    assign cs_s = pin_sync[0];
    assign clear_n_s = pin_sync[1];
    assign load_n_s = pin_sync[2];
    assign manual_s = pin_sync[3];
    assign strap_s = pin_sync[6:4];
    assign toggle_s = pin_sync[7];

    // ============================================================
    // Frame end detection
    // Chip select is delayed one more stage so the toggle, which
    // flips only a few ns before the rise, is surely seen first.
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            cs_late <= 1'b1;
            cs_late2 <= 1'b1;
        end else begin
            cs_late <= cs_s;
            cs_late2 <= cs_late;
        end
    end

    // Remember the last toggle value consumed at a frame end
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            toggle_seen <= 1'b0;
        end else if (cs_late && !cs_late2) begin
            toggle_seen <= toggle_s;
        end
    end

    // Frame word and count are frozen while chip select is high
    assign frame_go = cs_late && !cs_late2 &&
        (toggle_s != toggle_seen) &&
        (xfer.bit_count == `FRAME_BITS);
    assign cmd = xfer.frame_word[`CMD_MSB:`CMD_LSB];
    assign data = xfer.frame_word[`DATA_MSB:0];

    // ============================================================
    // Command decode
    assign wr_code_go = frame_go && ((cmd == `CMD_WR_CODE) ||
        (cmd == `CMD_WR_CODE_UPD));
    assign wr_span_go = frame_go && ((cmd == `CMD_WR_SPAN) ||
        (cmd == `CMD_WR_SPAN_UPD));
    // Load pin is locked out while the chip is selected
    assign load_go = !load_n_s && cs_s;
    assign upd_go = load_go || (frame_go && ((cmd == `CMD_UPDATE) ||
        (cmd == `CMD_WR_SPAN_UPD) || (cmd == `CMD_WR_CODE_UPD)));

    // Write and update in one frame: DAC takes the new input value
    always_comb begin
        next_in_code = in_code;
        next_in_span = in_span;
        if (wr_code_go) begin
            next_in_code = data[`DATA_MSB:`CODE_LSB];
        end
        if (wr_span_go) begin
            next_in_span = data[`SPAN_MSB:`SPAN_LSB];
        end
    end

    // ============================================================
    // Input registers: writes land here only
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            in_code <= `RESET_CODE;
            in_span <= `RESET_SPAN;
        end else begin
            in_code <= next_in_code;
            in_span <= next_in_span;
        end
    end

    // ============================================================
    // DAC registers: clear wins over any update
    always_ff @(posedge clock) begin
        if (sys_rst || !clear_n_s) begin
            dac_code <= `RESET_CODE;
            dac_span <= `RESET_SPAN;
        end else if (upd_go) begin
            dac_code <= next_in_code;
            dac_span <= next_in_span;
        end
    end

    // ============================================================
    // Active range: straps in manual mode, else the DAC register
    assign live_span = manual_s ? {1'b0, strap_s} : dac_span;

    // Registered so the range output comes from a flop; it loads on
    // the same edge as the DAC register, matching the code's own flop.
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            dac_range <= `RESET_SPAN;
        end else if (manual_s) begin
            dac_range <= {1'b0, strap_s};
        end else if (!clear_n_s) begin
            dac_range <= `RESET_SPAN;
        end else if (upd_go) begin
            dac_range <= next_in_span;
        end else begin
            dac_range <= dac_span;
        end
    end

    // ============================================================
    // Reset flag: low after reset or clear, high on an update
    always_ff @(posedge clock) begin
        if (sys_rst || !clear_n_s) begin
            reset_flag_n <= 1'b0;
        end else if (upd_go) begin
            reset_flag_n <= 1'b1;
        end
    end

    // ============================================================
    // Rolling readback pointer for the next frame
    always_ff @(posedge clock) begin
        if (sys_rst || !clear_n_s) begin
            rb_ptr <= PTR_DAC_SPAN;
        end else if (frame_go) begin
            case (cmd)
                `CMD_WR_SPAN: begin
                    rb_ptr <= PTR_IN_SPAN;
                end
                `CMD_WR_CODE: begin
                    rb_ptr <= PTR_IN_CODE;
                end
                `CMD_UPDATE, `CMD_WR_SPAN_UPD: begin
                    rb_ptr <= PTR_DAC_SPAN;
                end
                `CMD_WR_CODE_UPD, `CMD_NOP: begin
                    rb_ptr <= PTR_DAC_CODE;
                end
                `CMD_RD_IN_SPAN: begin
                    rb_ptr <= PTR_IN_SPAN;
                end
                `CMD_RD_IN_CODE: begin
                    rb_ptr <= PTR_IN_CODE;
                end
                `CMD_RD_DAC_SPAN: begin
                    rb_ptr <= PTR_DAC_SPAN;
                end
                `CMD_RD_DAC_CODE: begin
                    rb_ptr <= PTR_DAC_CODE;
                end
                default: begin
                    rb_ptr <= rb_ptr; // Reserved codes do nothing
                end
            endcase
        end
    end

    // ============================================================
    // Readback words offered to the shifter
    // Except under clear or a range strap change in manual mode, these
    // change only between frames, so the serial side may pick one up
    // at the command byte without a further crossing.
    assign xfer.rb_in_span = span_word(in_span);
    assign xfer.rb_in_code = code_word(in_code);
    assign xfer.rb_dac_span = span_word(live_span); // Actual range
    assign xfer.rb_dac_code = code_word(dac_code);

    always_comb begin
        case (rb_ptr)
            PTR_IN_SPAN: begin
                xfer.rb_roll = span_word(in_span);
            end
            PTR_IN_CODE: begin
                xfer.rb_roll = code_word(in_code);
            end
            PTR_DAC_CODE: begin
                xfer.rb_roll = code_word(dac_code);
            end
            default: begin
                xfer.rb_roll = span_word(live_span);
            end
        endcase
    end

    // ============================================================
    // Readback pin enable
    // Follows synchronised chip select, so it lags the pin by two
    // to three system cycles on both edges.
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            serial_readback_oe <= 1'b0;
        end else begin
            serial_readback_oe <= !cs_s;
        end
    end

endmodule // dac_serial_double_buffered_regs

/* File: dac_ctrl_props.sv */
// Checker for the converter control block, on the top module's ports.
// Assumes the bind below; only the system clock domain is watched.
`timescale 1ns/1ps

module dac_ctrl_props (
    // Clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // Observed pins
    input wire logic chip_select_load,
    input wire logic serial_readback_out,
    input wire logic serial_readback_oe,
    input wire logic async_clear_n,
    input wire logic async_load_n,
    input wire logic manual_range_select,
    input wire logic range_strap_0,
    input wire logic range_strap_1,
    input wire logic range_strap_2,
    input wire logic [17:0] dac_code,
    input wire logic [3:0] dac_range,
    input wire logic reset_flag_n
);
    // ============================================================
    // Clocking and strap bundle
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);
    wire [2:0] straps = {range_strap_2, range_strap_1, range_strap_0};

    // ============================================================
    // Pins are synchronised, so each window allows for 2-3 clocks
    a_clear_zero_code: assert property ((!async_clear_n)[*4] |->
        dac_code == 18'h00000) else $error("code not zero under clear");
    a_clear_flag_low: assert property ((!async_clear_n)[*4] |->
        !reset_flag_n) else $error("flag high under clear");
    a_load_sets_flag: assert property (
        (!async_load_n && chip_select_load && async_clear_n)[*4]
        |-> reset_flag_n) else $error("load did not raise flag");
    a_oe_off_idle: assert property (chip_select_load[*4] |->
        !serial_readback_oe) else $error("readback driven while idle");
    a_rb_low_idle: assert property (chip_select_load[*4] |->
        !serial_readback_out) else $error("readback not low while idle");
    a_manual_straps: assert property (
        (manual_range_select && $stable(straps))[*4]
        |-> dac_range == {1'b0, straps}) else $error("range not straps");
    // Nothing but clear or manual straps takes effect while a frame is still being shifted
    a_code_hold_sel: assert property (
        (!chip_select_load && async_clear_n)[*8] |-> $stable(dac_code))
        else $error("code moved during frame");
    a_flag_hold_sel: assert property (
        (!chip_select_load && async_clear_n)[*8] |-> $stable(reset_flag_n))
        else $error("flag moved during frame");
    a_range_hold_sel: assert property (
        (!chip_select_load && async_clear_n && !manual_range_select)[*8]
        |-> $stable(dac_range)) else $error("range moved during frame");
endmodule // dac_ctrl_props

bind dac_serial_double_buffered_regs dac_ctrl_props i_props (
    .clock, .sys_rst, .chip_select_load, .serial_readback_out,
    .serial_readback_oe, .async_clear_n, .async_load_n,
    .manual_range_select, .range_strap_0, .range_strap_1, .range_strap_2,
    .dac_code, .dac_range, .reset_flag_n);

/* File: spi_host_model.sv */
// Host side of the four-wire link: a behavioural serial master.
// Assumes the bench resolves the shared readback line for it.
`timescale 1ns/1ps

module spi_host_model (
    // Link pins driven by the host
    output logic serial_clock,
    output logic chip_select_load,
    output logic serial_data_in,
    // Resolved readback line
    input wire logic readback_line
);
    realtime half_period = 3.0;

    // Idle: clock parked low, not selected
    initial begin
        serial_clock = 1'b0;
        chip_select_load = 1'b1;
        serial_data_in = 1'b1;
    end

    // One frame MSB first; a short count models a broken frame
    task automatic frame(input logic [3:0] cmd, input logic [23:0] data,
        input int nbits, output logic [23:0] rb);
        logic [31:0] word;
        word = {cmd, 4'h0, data};
        rb = 24'h000000;
        chip_select_load = 1'b0;
        // Long lead-in so the synchronised enable is up before bit 9
        #101.3;
        for (int i = 0; i < nbits; i++) begin
            serial_data_in = word[31 - i];
            #(half_period) serial_clock = 1'b1;
            if (i >= 8) rb[31 - i] = readback_line;
            #(half_period) serial_clock = 1'b0;
        end
        serial_data_in = ~serial_data_in; // No stale bit after release
        #(half_period) chip_select_load = 1'b1;
        #250; // Gap well over six system clocks
    endtask
endmodule // spi_host_model

/* File: tb.sv */
// Self-checking bench for the converter control block.
// Assumes the package, header, checker and host model compile first.
`timescale 1ns/1ps
`include "dac_ctrl_consts.svh"

module tb;
    import dac_ctrl_pkg::*;
    // ============================================================
    // Signals
    logic clock, sys_rst, async_clear_n, async_load_n, manual_range_select;
    logic [2:0] straps;
    logic serial_clock, chip_select_load, serial_data_in;
    logic serial_readback_out, serial_readback_oe, reset_flag_n;
    logic [17:0] dac_code;
    logic [3:0] dac_range;
    logic [23:0] rb, prev;
    logic [17:0] c1 = 18'h2a5c3;
    logic [17:0] c2 = 18'h1137e;
    logic [17:0] c3 = 18'h3fffe;
    int n_errors = 0;
    int n_tests = 0;
    // Released line floats: show the inverse, never a stale bit
    wire readback_line = serial_readback_oe ? serial_readback_out :
        ~serial_readback_out;

    dac_serial_double_buffered_regs i_dut (.clock, .sys_rst,
        .serial_clock, .chip_select_load, .serial_data_in,
        .serial_readback_out, .serial_readback_oe, .async_clear_n,
        .async_load_n, .manual_range_select, .range_strap_0(straps[0]),
        .range_strap_1(straps[1]), .range_strap_2(straps[2]),
        .dac_code, .dac_range, .reset_flag_n);
    spi_host_model i_host (.serial_clock, .chip_select_load,
        .serial_data_in, .readback_line);

    // ============================================================
    // Tasks
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("FAIL at %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic ticks(input int n);
        repeat (n) @(negedge clock);
    endtask
    task automatic xfer(input logic [3:0] cmd, input logic [23:0] data);
        i_host.frame(cmd, data, 32, rb);
        @(negedge clock);
    endtask
    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    // System clock, 25 ns
    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end
    // Watchdog far beyond the roughly 12 us the tests take
    initial begin
        #100us;
        n_errors++;
        $display("FAIL at %0t got %h expected %h", $time, 1'b0, 1'b1);
        print_verdict();
    end

    // ============================================================
    // Main sequence
    initial begin
        sys_rst = 1'b0;
        async_clear_n = 1'b1;
        async_load_n = 1'b1;
        manual_range_select = 1'b0;
        straps = 3'h0;
        // Reset rises after time zero so the async resets see an edge
        #1;
        sys_rst = 1'b1;
        ticks(2);
        sys_rst = 1'b0;
        ticks(2);
        chk({6'h00, dac_code}, 24'h000000);
        chk({23'h0, reset_flag_n}, 24'h000000);
        xfer(`CMD_NOP, 24'h000000);
        chk(rb, 24'h000000);
        xfer(`CMD_WR_CODE, {c1, 6'h00});
        chk({6'h00, dac_code}, 24'h000000);
        xfer(`CMD_WR_SPAN, 24'h000200);
        chk(rb, {c1, 6'h00});
        chk({20'h0, dac_range}, 24'h000000);
        xfer(`CMD_RD_IN_CODE, 24'h000000);
        chk(rb, {c1, 6'h00});
        xfer(`CMD_UPDATE, 24'hffffff);
        chk({6'h00, dac_code}, {6'h00, c1});
        chk({20'h0, dac_range}, 24'h000002);
        chk({23'h0, reset_flag_n}, 24'h000001);
        // Broken frame of 31 bits must leave the input code alone
        i_host.frame(`CMD_WR_CODE, {c2, 6'h3f}, 31, rb);
        xfer(`CMD_RD_IN_CODE, 24'h000000);
        chk(rb, {c1, 6'h00});
        prev = {c1, 6'h00};
        for (int r = 0; r < 6; r++) begin
            xfer(`CMD_WR_SPAN_UPD, {12'h000, 4'(r), 8'h00});
            chk(rb, prev);
            chk({20'h0, dac_range}, {20'h0, 4'(r)});
            prev = {12'h000, 4'(r), 8'h00};
        end
        xfer(4'h5, 24'h000100);
        chk({20'h0, dac_range}, 24'h000005);
        xfer(`CMD_WR_CODE_UPD, {c2, 6'h2b});
        chk(rb, prev);
        chk({6'h00, dac_code}, {6'h00, c2});
        // Load pulse inside a frame is locked out
        xfer(`CMD_WR_CODE, {c3, 6'h00});
        fork
            i_host.frame(`CMD_NOP, 24'h000000, 32, rb);
            begin
                ticks(3);
                async_load_n = 1'b0;
                ticks(4);
                async_load_n = 1'b1;
            end
        join
        @(negedge clock);
        chk(rb, {c3, 6'h00});
        chk({6'h00, dac_code}, {6'h00, c2});
        async_clear_n = 1'b0;
        ticks(4);
        chk({6'h00, dac_code}, 24'h000000);
        chk({20'h0, dac_range}, 24'h000000);
        chk({23'h0, reset_flag_n}, 24'h000000);
        async_clear_n = 1'b1;
        ticks(2);
        // Load after clear: flag must come back up with the update
        async_load_n = 1'b0;
        ticks(4);
        async_load_n = 1'b1;
        ticks(1);
        chk({6'h00, dac_code}, {6'h00, c3});
        chk({20'h0, dac_range}, 24'h000005);
        chk({23'h0, reset_flag_n}, 24'h000001);
        xfer(`CMD_RD_IN_CODE, 24'h000000);
        chk(rb, {c3, 6'h00});
        // Strapped range wins over the serial port
        straps = 3'h3;
        manual_range_select = 1'b1;
        ticks(4);
        chk({20'h0, dac_range}, 24'h000003);
        xfer(`CMD_WR_SPAN_UPD, 24'h000100);
        chk({20'h0, dac_range}, 24'h000003);
        xfer(`CMD_RD_DAC_SPAN, 24'h000000);
        chk(rb, 24'h000300);
        // Back to programmed range; straps must then be ignored
        manual_range_select = 1'b0;
        xfer(`CMD_WR_SPAN_UPD, 24'h000400);
        chk({20'h0, dac_range}, 24'h000004);
        straps = 3'h6;
        ticks(4);
        chk({20'h0, dac_range}, 24'h000004);
        print_verdict();
    end
endmodule // tb
